// *** sioa_top.v ***
// sioa_top.v: special I/O pin access unit with register port, pwm, frequency and edge events
// assumes pins and converter codes synchronous to MCLK, converter codes already 10-bit
`include "sioa_map.vh"

// Behaviour
// - digital pin read returns only zero for low or one for high
// - read naming a nonexistent pin returns zero
// - converter pin read returns unsigned code within configured resolution
// - write naming a nonexistent pin changes nothing at all
// - digital output: zero written drives low, nonzero drives high
// - duty output: written value sets high time, full scale gives constant high
// - frequency output: written value is square wave frequency in hertz
// - frequency of zero holds the pin steadily low
// - frequency above four megahertz saturates at four megahertz
// - analogue output takes the written value unchanged
// - event channel attaches to a digital input pin edge
// - edge code 0 rising, 1 falling, 2 both directions
// - edge on channel n raises event n
// - duty counter is 32-bit, stepping at 1 MHz, period equals full scale
// - duty value at or above full scale gives constant high
module sioa_top (
  input wire MCLK,
  input wire SYS_RST,
  input wire CE,
  input wire [5:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] PIN_I,
  input wire [79:0] ADC_CODE,
  output reg [31:0] RDATA,
  output reg [7:0] PIN_O,
  output reg [7:0] PIN_OE,
  output reg [255:0] ANA_OUT,
  output reg [3:0] EVENT,
  output reg IRQ
);

  localparam [5:0] PWM_DIV_M1 = `SIOA_PWM_DIV_M1;
  localparam [31:0] FREQ_MAX = `SIOA_FREQ_MAX_HZ;
  localparam [24:0] HALF_CLK = `SIOA_HALF_CLK;

  // checks that a pin number names an existing pin
  function pin_ok;
    input [31:0] num;
    begin
      pin_ok = (num < `SIOA_NPIN);
    end
  endfunction

  // decides whether an edge qualifies under an edge select code
  function edge_hit;
    input [1:0] code;
    input rise;
    input fall;
    begin
      case (code)
        `SIOA_EDGE_RISE: edge_hit = rise;
        `SIOA_EDGE_FALL: edge_hit = fall;
        `SIOA_EDGE_BOTH: edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // clips a requested frequency to the 4 MHz ceiling
  function [24:0] freq_clip;
    input [31:0] hz;
    begin
      freq_clip = (hz > FREQ_MAX) ? FREQ_MAX[24:0] : hz[24:0];
    end
  endfunction

  reg [31:0] pin_select_number;
  reg [31:0] duty_full_scale_value;
  reg [23:0] func;
  reg [31:0] pin_write_value [0:7];
  reg [3:0] ch_en;
  reg [2:0] ch_pin [0:3];
  reg [1:0] edge_select_code [0:3];
  reg [3:0] sts;
  reg [3:0] msk;
  reg [7:0] sync_a;
  reg [7:0] sync_b;
  reg [7:0] sync_prev;
  reg [5:0] pwm_div;
  reg [31:0] pwm_cnt;
  reg [24:0] acc [0:7];
  reg [7:0] sq;

  wire wr_sel = WR && (ADDR == `SIOA_OFS_SEL);
  wire pin_write_request = WR && (ADDR == `SIOA_OFS_VAL);
  wire pin_read_request = RD && (ADDR == `SIOA_OFS_RDV);
  wire wr_full = WR && (ADDR == `SIOA_OFS_FULL);
  wire wr_func = WR && (ADDR == `SIOA_OFS_FUNC);
  wire edge_event_attach = WR && (ADDR == `SIOA_OFS_ATT);
  wire wr_sts = WR && (ADDR == `SIOA_OFS_STS);
  wire wr_msk = WR && (ADDR == `SIOA_OFS_MSK);
  wire sel_ok = pin_ok(pin_select_number);
  wire [2:0] sel_idx = pin_select_number[2:0];
  wire [1:0] att_ch = WDATA[`SIOA_ATT_CH_LSB +: 2];
  wire [7:0] att_pin = WDATA[`SIOA_ATT_PIN_LSB +: 8];
  wire [1:0] att_code = WDATA[`SIOA_ATT_CODE_LSB +: 2];
  wire att_en = WDATA[`SIOA_ATT_EN_BIT];
  wire pwm_tick = (pwm_div == PWM_DIV_M1);
  wire [2:0] sel_func = func[sel_idx * `SIOA_FUNC_W +: `SIOA_FUNC_W];

  // read data of the pin access register
  reg [31:0] pin_value;
  always @* begin
    pin_value = 32'h00000000;
    if (sel_ok) begin
      if (sel_func == `SIOA_FN_AIN)
        pin_value = {22'h000000, ADC_CODE[sel_idx * `SIOA_ADC_W +: `SIOA_ADC_W]};
      else
        pin_value = {31'h00000000, sync_b[sel_idx]};
    end
  end

  // register read mux
  reg [31:0] next_rdata;
  always @* begin
    case (ADDR)
      `SIOA_OFS_SEL: next_rdata = pin_select_number;
      `SIOA_OFS_VAL: next_rdata = sel_ok ? pin_write_value[sel_idx] : 32'h00000000;
      `SIOA_OFS_RDV: next_rdata = pin_value;
      `SIOA_OFS_FULL: next_rdata = duty_full_scale_value;
      `SIOA_OFS_FUNC: next_rdata = {8'h00, func};
      `SIOA_OFS_ATT: next_rdata = {28'h0000000, ch_en};
      `SIOA_OFS_STS: next_rdata = {28'h0000000, sts};
      `SIOA_OFS_MSK: next_rdata = {28'h0000000, msk};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // per-pin output drive
  reg [7:0] next_o;
  reg [7:0] next_oe;
  reg [2:0] fn;
  integer i;
  always @* begin
    next_o = 8'h00;
    next_oe = 8'h00;
    fn = 3'h0;
    for (i = 0; i < `SIOA_NPIN; i = i + 1) begin
      fn = func[i * `SIOA_FUNC_W +: `SIOA_FUNC_W];
      case (fn)
        `SIOA_FN_DOUT: begin
          next_o[i] = |pin_write_value[i];
          next_oe[i] = 1'b1;
        end
        `SIOA_FN_PWM: begin
          next_o[i] = (pin_write_value[i] >= duty_full_scale_value) ||
            (pwm_cnt < pin_write_value[i]);
          next_oe[i] = 1'b1;
        end
        `SIOA_FN_FREQ: begin
          next_o[i] = sq[i];
          next_oe[i] = 1'b1;
        end
        default: begin
          next_o[i] = 1'b0;
          next_oe[i] = 1'b0;
        end
      endcase
    end
  end

  // edge detection per channel
  reg [3:0] next_event;
  reg [2:0] cp;
  integer c;
  always @* begin
    next_event = 4'h0;
    cp = 3'h0;
    for (c = 0; c < `SIOA_NCH; c = c + 1) begin
      cp = ch_pin[c];
      if (ch_en[c] && func[cp * `SIOA_FUNC_W +: `SIOA_FUNC_W] == `SIOA_FN_DIN)
        next_event[c] = edge_hit(edge_select_code[c],
          sync_b[cp] & ~sync_prev[cp], ~sync_b[cp] & sync_prev[cp]);
    end
  end

  // register file, bus answer and flag logic
  integer k;
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      RDATA <= 32'h00000000;
      pin_select_number <= `SIOA_RST_SEL;
      duty_full_scale_value <= `SIOA_RST_FULL;
      func <= `SIOA_RST_FUNC;
      ch_en <= 4'h0;
      sts <= 4'h0;
      msk <= 4'h0;
      EVENT <= 4'h0;
      IRQ <= 1'b0;
      ANA_OUT <= 256'h0;
      for (k = 0; k < `SIOA_NPIN; k = k + 1) begin
        pin_write_value[k] <= 32'h00000000;
      end
      for (k = 0; k < `SIOA_NCH; k = k + 1) begin
        ch_pin[k] <= 3'h0;
        edge_select_code[k] <= 2'h0;
      end
    end else if (CE) begin
      RDATA <= RD ? next_rdata : 32'h00000000;
      if (wr_sel)
        pin_select_number <= WDATA;
      if (wr_full)
        duty_full_scale_value <= WDATA;
      if (wr_func)
        func <= WDATA[23:0];
      if (wr_msk)
        msk <= WDATA[3:0];
      if (pin_write_request && sel_ok) begin
        pin_write_value[sel_idx] <= WDATA;
        if (sel_func == `SIOA_FN_AOUT)
          ANA_OUT[sel_idx * 32 +: 32] <= WDATA;
      end
      if (edge_event_attach && pin_ok({24'h000000, att_pin})) begin
        ch_en[att_ch] <= att_en;
        ch_pin[att_ch] <= att_pin[2:0];
        edge_select_code[att_ch] <= att_code;
      end
      EVENT <= next_event;
      sts <= (sts & ~(wr_sts ? WDATA[3:0] : 4'h0)) | next_event;
      IRQ <= |(sts & msk);
    end
  end

  // input synchroniser and edge history
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
      sync_prev <= 8'h00;
    end else if (CE) begin
      sync_a <= PIN_I;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // 1 MHz duty timer
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      pwm_div <= 6'h00;
      pwm_cnt <= 32'h00000000;
    end else if (CE) begin
      pwm_div <= pwm_tick ? 6'h00 : pwm_div + 6'h01;
      if (pwm_tick) begin
        if (pwm_cnt + 32'h00000001 >= duty_full_scale_value)
          pwm_cnt <= 32'h00000000;
        else
          pwm_cnt <= pwm_cnt + 32'h00000001;
      end
    end
  end

  // square wave generators: toggle at twice the requested rate
  reg [199:0] asum;
  integer g;
  always @* begin
    asum = 200'h0;
    for (g = 0; g < `SIOA_NPIN; g = g + 1) begin
      asum[g * 25 +: 25] = acc[g] + freq_clip(pin_write_value[g]);
    end
  end

  integer f;
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      sq <= 8'h00;
      for (f = 0; f < `SIOA_NPIN; f = f + 1) begin
        acc[f] <= 25'h0000000;
      end
    end else if (CE) begin
      for (f = 0; f < `SIOA_NPIN; f = f + 1) begin
        if (pin_write_value[f] == 32'h00000000 ||
            func[f * `SIOA_FUNC_W +: `SIOA_FUNC_W] != `SIOA_FN_FREQ) begin
          acc[f] <= 25'h0000000;
          sq[f] <= 1'b0;
        end else if (asum[f * 25 +: 25] >= HALF_CLK) begin
          acc[f] <= asum[f * 25 +: 25] - HALF_CLK;
          sq[f] <= ~sq[f];
        end else begin
          acc[f] <= asum[f * 25 +: 25];
        end
      end
    end
  end

  // pin drive registers
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      PIN_O <= 8'h00;
      PIN_OE <= 8'h00;
    end else if (CE) begin
      PIN_O <= next_o;
      PIN_OE <= next_oe;
    end
  end

endmodule // sioa_top

// *** sioa_map.vh ***
// sioa_map.vh: offsets, fields, reset values and timing counts of the special I/O unit
// assumes a 50 MHz system clock and 32-bit register data
`ifndef SIOA_MAP_VH
`define SIOA_MAP_VH

// register byte offsets
`define SIOA_OFS_SEL 6'h00
`define SIOA_OFS_VAL 6'h04
`define SIOA_OFS_RDV 6'h08
`define SIOA_OFS_FULL 6'h0c
`define SIOA_OFS_FUNC 6'h10
`define SIOA_OFS_ATT 6'h14
`define SIOA_OFS_STS 6'h18
`define SIOA_OFS_MSK 6'h1c

// geometry
`define SIOA_NPIN 8
`define SIOA_NCH 4
`define SIOA_ADC_W 10
`define SIOA_FUNC_W 3

// pin function codes
`define SIOA_FN_DIN 3'h0
`define SIOA_FN_DOUT 3'h1
`define SIOA_FN_PWM 3'h2
`define SIOA_FN_FREQ 3'h3
`define SIOA_FN_AIN 3'h4
`define SIOA_FN_AOUT 3'h5

// attach register fields
`define SIOA_ATT_CH_LSB 0
`define SIOA_ATT_PIN_LSB 4
`define SIOA_ATT_CODE_LSB 12
`define SIOA_ATT_EN_BIT 16

// edge select codes
`define SIOA_EDGE_RISE 2'h0
`define SIOA_EDGE_FALL 2'h1
`define SIOA_EDGE_BOTH 2'h2

// reset values
`define SIOA_RST_FUNC 24'h000000
`define SIOA_RST_FULL 32'h000003e8
`define SIOA_RST_SEL 32'h00000000

// timing
`define SIOA_CLK_HZ 50000000
`define SIOA_PWM_TICK_HZ 1000000
// clock cycles per duty tick, minus one
`define SIOA_PWM_DIV_M1 6'h31
`define SIOA_FREQ_MAX_HZ 32'h003d0900
// half the clock rate, toggle threshold of the square wave accumulator
`define SIOA_HALF_CLK 25'h17d7840

`endif

// *** sioa_checker.sv ***
// sioa_checker.sv: port assertions for the special I/O unit
// assumes CE low only while the bus is idle and sioa_map.vh on the include path
`include "sioa_map.vh"
module sioa_checker (
  input wire MCLK,
  input wire SYS_RST,
  input wire [5:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] PIN_I,
  input wire [31:0] RDATA,
  input wire [255:0] ANA_OUT,
  input wire [3:0] EVENT,
  input wire IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] sel;
  reg [23:0] fn;
  wire wv = WR && ADDR == `SIOA_OFS_VAL && sel < 8;
  wire rdv = RD && ADDR == `SIOA_OFS_RDV;
  wire [2:0] f = fn[sel[2:0]*3 +: 3];
  wire [2:0] si = sel[2:0];
  wire ev_any = |EVENT;
  // shadow of the pin select and function registers
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      sel <= 32'h0;
      fn <= 24'h0;
    end else if (WR && ADDR == `SIOA_OFS_SEL) begin
      sel <= WDATA;
    end else if (WR && ADDR == `SIOA_OFS_FUNC) begin
      fn <= WDATA[23:0];
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  property p_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_bad; rdv && sel > 7 |=> RDATA == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("absent pin read not zero");
  property p_dig; rdv && sel < 8 && f != `SIOA_FN_AIN |=> RDATA < 32'h2; endproperty
  a_dig: assert property (p_dig) else $error("digital read not 0 or 1");
  property p_adc; rdv && sel < 8 && f == `SIOA_FN_AIN |=> RDATA < 32'h400; endproperty
  a_adc: assert property (p_adc) else $error("converter read out of range");
  property p_ana;
    wv && f == `SIOA_FN_AOUT |=> ANA_OUT[$past(si)*32 +: 32] == $past(WDATA);
  endproperty
  a_ana: assert property (p_ana) else $error("analogue level not taken");
  property p_hold; $changed(ANA_OUT) |-> $past(wv); endproperty
  a_hold: assert property (p_hold) else $error("analogue level changed unasked");
  property p_ev;
    |EVENT |-> $past(PIN_I, 2) != $past(PIN_I, 3) || $past(PIN_I, 3) != $past(PIN_I, 4);
  endproperty
  a_ev: assert property (p_ev) else $error("event without input edge");
  property p_irq; $rose(IRQ) |-> $past(ev_any) || $past(WR) || $past(WR, 2); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  c_ev: cover property (|EVENT);
  c_irq: cover property ($rose(IRQ));
  c_ana: cover property (wv);
endmodule // sioa_checker
bind sioa_top sioa_checker chk_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .PIN_I(PIN_I), .RDATA(RDATA), .ANA_OUT(ANA_OUT), .EVENT(EVENT), .IRQ(IRQ));

// *** sioa_pin_model.sv ***
// sioa_pin_model.sv: pin wires and converter sources facing the special I/O unit
// assumes the bench sets external levels just after a rising clock edge
module sioa_pin_model (
  input wire [7:0] ext_lvl,
  input wire [7:0] pin_o,
  input wire [7:0] pin_oe,
  output logic [7:0] pin_i,
  output logic [79:0] adc
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin reads back its own level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
  always_comb for (int n = 0; n < 8; n++) adc[n*10 +: 10] = 10'h2a3 ^ 10'(n);
endmodule // sioa_pin_model

// *** test_special_io_pin_access_unit.sv ***
// test_special_io_pin_access_unit.sv: self-checking bench of the special I/O unit
// assumes sioa_top, sioa_pin_model and the bound checker are compiled first
`include "sioa_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module test_special_io_pin_access_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, sys_rst = 1, wr_s = 0, rd_s = 0, ce = 1;
  logic [5:0] addr = 0;
  logic [31:0] wdata = 0, rdata, r;
  logic [7:0] lvl = 0, pin_i, pin_o, pin_oe;
  logic [79:0] adc;
  logic [255:0] ana_out, a0;
  logic [3:0] event_s;
  logic irq;
  int error_cnt = 0, checks = 0, c, ev[4];
  int exp_ev[$];
  always #10 mclk = ~mclk;
  sioa_top dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .PIN_I(pin_i), .ADC_CODE(adc), .RDATA(rdata), .PIN_O(pin_o),
    .PIN_OE(pin_oe), .ANA_OUT(ana_out), .EVENT(event_s), .IRQ(irq));
  sioa_pin_model pm_u (.ext_lvl(lvl), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i), .adc(adc));
  always @(negedge mclk) for (int i = 0; i < 4; i++) ev[i] += event_s[i];
  // expected event count of a channel from its edge code and the edges applied
  function automatic int ev_model(int code, int rises, int falls);
    return (code == 0 || code == 2 ? rises : 0) + (code == 1 || code == 2 ? falls : 0);
  endfunction
  task wr(input [5:0] a, input [31:0] d);
    @(posedge mclk); addr <= a; wdata <= d; wr_s <= 1;
    @(posedge mclk); wr_s <= 0;
  endtask
  task rd(input [5:0] a);
    @(posedge mclk); addr <= a; rd_s <= 1;
    @(posedge mclk); rd_s <= 0;
    @(negedge mclk); r = rdata;
  endtask
  task cnt(input int p, input int n, input bit tg);
    bit prv;
    @(negedge mclk);
    prv = pin_o[p];
    c = 0;
    repeat (n) begin
      @(negedge mclk); c += tg ? int'(pin_o[p] != prv) : int'(pin_o[p]); prv = pin_o[p];
    end
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #300000; error_cnt++; complete_run;
  end
  initial begin
    void'($urandom(67774));
    repeat (4) @(posedge mclk);
    sys_rst <= 0;
    rd(`SIOA_OFS_FULL); `CHK(r, `SIOA_RST_FULL)
    wr(`SIOA_OFS_SEL, 9); rd(`SIOA_OFS_RDV); `CHK(r, 32'h0)
    done("reset");
    @(posedge mclk) lvl <= $urandom;
    for (int p = 0; p < 8; p++) begin
      wr(`SIOA_OFS_SEL, p); rd(`SIOA_OFS_RDV); `CHK(r, {31'h0, lvl[p]})
    end
    done("digital read");
    wr(`SIOA_OFS_FUNC, 32'h006a8108);
    wr(`SIOA_OFS_SEL, 2); rd(`SIOA_OFS_RDV); `CHK(r, {22'h0, 10'h2a1})
    `CHK(pin_oe, 8'hc2)
    wr(`SIOA_OFS_SEL, 1); wr(`SIOA_OFS_VAL, $urandom | 32'h2);
    repeat (3) @(negedge mclk); `CHK(pin_o[1], 1'b1)
    wr(`SIOA_OFS_VAL, 0); repeat (3) @(negedge mclk); `CHK(pin_o[1], 1'b0)
    c = $urandom; wr(`SIOA_OFS_SEL, 5); wr(`SIOA_OFS_VAL, c);
    @(negedge mclk); `CHK(ana_out[191:160], 32'(c))
    a0 = ana_out; wr(`SIOA_OFS_SEL, 8); wr(`SIOA_OFS_VAL, 1);
    repeat (3) @(negedge mclk); `CHK({ana_out, pin_o[1]}, {a0, 1'b0})
    done("outputs");
    wr(`SIOA_OFS_SEL, 7); wr(`SIOA_OFS_VAL, 0); cnt(7, 200, 0); `CHK(c, 0)
    for (int i = 0; i < 2; i++) begin
      wr(`SIOA_OFS_VAL, 4000000 + i * 5000000); repeat (10) @(posedge mclk);
      cnt(7, 250, 1); `CHK(c, 40)
    end
    @(posedge mclk) ce <= 0;
    cnt(7, 20, 1); `CHK(c, 0)
    @(posedge mclk) ce <= 1;
    wr(`SIOA_OFS_FULL, 4); wr(`SIOA_OFS_SEL, 6);
    for (int i = 1; i < 4; i++) begin
      wr(`SIOA_OFS_VAL, i * i); repeat (210) @(posedge mclk);
      cnt(6, 800, 0); `CHK(c, i > 1 ? 800 : 200)
    end
    done("timers");
    wr(`SIOA_OFS_MSK, 32'h4); @(posedge mclk) lvl[3] <= 0;
    for (int k = 0; k < 3; k++) begin
      wr(`SIOA_OFS_ATT, 32'h10030 | k << 12 | k);
      exp_ev.push_back(ev_model(k, 1, 1));
    end
    wr(`SIOA_OFS_ATT, 32'h10093);
    exp_ev.push_back(0);
    @(posedge mclk) ev = '{0, 0, 0, 0};
    @(posedge mclk) lvl[3] <= 1;
    repeat (10) @(posedge mclk); lvl[3] <= 0;
    repeat (10) @(negedge mclk);
    for (int k = 0; k < 4; k++) `CHK(ev[k], exp_ev[k])
    `CHK(irq, 1'b1)
    rd(`SIOA_OFS_STS); `CHK(r[3:0], 4'h7)
    wr(`SIOA_OFS_STS, 32'hf); repeat (3) @(negedge mclk); `CHK(irq, 1'b0)
    done("events");
    complete_run;
  end
endmodule // test_special_io_pin_access_unit
